/* src/nvd_regs.sv */
/*
  nvd_regs: APB register block holding the data word and target address for
  program memory and configuration space accesses, plus a small read launcher.
  assumes: a memory array outside answers a read request with a 14-bit word
  and a one-cycle valid; no wait states are needed on the bus.
*/
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nvd_regs
  import nvd_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output wire logic              pready,
  output wire logic              pslverr,
  // memory array side
  output wire nvd_req_type       nvm_req,
  output wire logic              nvm_read_req,
  input  wire logic              nvm_read_valid,
  input  wire logic [WORD_W-1:0] nvm_read_word
);

  logic [7:0]             nvm_data_low;
  logic [DATA_HIGH_W-1:0] nvm_data_high;
  logic [7:0]             nvm_address_low;
  logic [ADDR_HIGH_W-1:0] nvm_address_high;
  logic                   config_space_select;
  nvd_state_type          state;
  nvd_state_type          next_state;
  logic [31:0]            next_prdata;
  logic                   cfg_readable;

  // bus decode
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire hit_dl   = (paddr == OFF_DATA_LOW);
  wire hit_dh   = (paddr == OFF_DATA_HIGH);
  wire hit_al   = (paddr == OFF_ADDR_LOW);
  wire hit_ah   = (paddr == OFF_ADDR_HIGH);
  wire hit_ctl  = (paddr == OFF_CONTROL);
  wire mapped   = hit_dl || hit_dh || hit_al || hit_ah || hit_ctl;
  wire wr       = access && pwrite && mapped;
  wire wr_dl    = wr && hit_dl;
  wire wr_dh    = wr && hit_dh;
  wire wr_al    = wr && hit_al;
  wire wr_ah    = wr && hit_ah;
  wire wr_ctl   = wr && hit_ctl;
  wire busy     = (state == NVD_READ_WAIT);

  // zero wait states keep the master simple
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // read start: a new one while busy is dropped
  wire start    = wr_ctl && pwdata[CTL_READ_START] && !busy;
  wire cfg_sel  = pwdata[CTL_CFG_SELECT];
  wire cfg_miss = start && cfg_sel && !cfg_readable;
  wire launch   = start && !cfg_miss;
  wire load     = busy && nvm_read_valid;
  wire clear    = cfg_miss;

  assign nvm_read_req = launch;

  // full address and program word toward the array
  assign nvm_req.addr      = {nvm_address_high, nvm_address_low};
  assign nvm_req.word      = {nvm_data_high, nvm_data_low};
  assign nvm_req.cfg_space = config_space_select;

  // window check uses the address the launch will present
  nvd_cfg_window u_window (
    .addr     (nvm_req.addr),
    .readable (cfg_readable)
  );

  // read mux, padded bits fixed by construction
  always_comb begin
    next_prdata = RDATA_RST;
    if (hit_dl) begin
      next_prdata[7:0] = nvm_data_low;
    end
    if (hit_dh) begin
      next_prdata[7:0] = {DATA_HIGH_PAD, nvm_data_high};
    end
    if (hit_al) begin
      next_prdata[7:0] = nvm_address_low;
    end
    if (hit_ah) begin
      next_prdata[7:0] = {ADDR_HIGH_PAD, nvm_address_high};
    end
    if (hit_ctl) begin
      next_prdata[CTL_CFG_SELECT] = config_space_select;
      next_prdata[CTL_BUSY]       = busy;
    end
  end

  // read data captured in setup so it is a flop during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_RST;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // address registers clear on every reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_address_low  <= ADDR_LOW_RST;
      nvm_address_high <= ADDR_HIGH_RST;
    end else begin
      if (wr_al) begin
        nvm_address_low <= pwdata[7:0];
      end
      if (wr_ah) begin
        nvm_address_high <= pwdata[ADDR_HIGH_W-1:0];
      end
    end
  end

  // data registers have no reset so their content outlives it;
  // an array answer beats a bus write in the same cycle
  always_ff @(posedge pclk) begin
    if (clear) begin
      nvm_data_low  <= DATA_CLEAR;
      nvm_data_high <= DATA_H_CLEAR;
    end else if (load) begin
      nvm_data_low  <= nvm_read_word[7:0];
      nvm_data_high <= nvm_read_word[WORD_W-1:8];
    end else begin
      if (wr_dl) begin
        nvm_data_low <= pwdata[7:0];
      end
      if (wr_dh) begin
        nvm_data_high <= pwdata[DATA_HIGH_W-1:0];
      end
    end
  end

  // control: space select and read launcher
  always_comb begin
    next_state = state;
    case (state)
      NVD_IDLE: begin
        if (launch) begin
          next_state = NVD_READ_WAIT;
        end
      end
      NVD_READ_WAIT: begin
        if (nvm_read_valid) begin
          next_state = NVD_IDLE;
        end
      end
      default: next_state = NVD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state               <= NVD_IDLE;
      config_space_select <= 1'b0;
    end else begin
      state <= next_state;
      if (wr_ctl) begin
        config_space_select <= cfg_sel;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg_miss;
    cfg_miss;
  endsequence
  sequence s_data_zero;
    (nvm_data_low == DATA_CLEAR) && (nvm_data_high == DATA_H_CLEAR);
  endsequence

  a_data_low_write: assert property (
    wr_dl && !clear && !load |=> nvm_data_low == $past(pwdata[7:0]))
    else $error("low data byte not stored");

  a_data_high_field: assert property (
    wr_dh && !clear && !load |=> nvm_req.word[13:8] == $past(pwdata[5:0]))
    else $error("high data bits not stored");

  a_data_high_pad: assert property (
    setup && !pwrite && hit_dh |=> prdata[7:6] == DATA_HIGH_PAD)
    else $error("high data pad not zero");

  a_addr_low_write: assert property (
    wr_al |=> nvm_req.addr[7:0] == $past(pwdata[7:0]))
    else $error("low address not stored");

  // store and hold checked apart, so a lost write cannot pass vacuously
  a_addr_high_write: assert property (
    wr_ah |=> nvm_req.addr[14:8] == $past(pwdata[6:0]))
    else $error("high address not stored");

  a_addr_high_hold: assert property (
    !wr_ah |=> nvm_req.addr[14:8] == $past(nvm_req.addr[14:8]))
    else $error("high address changed without a write");

  a_addr_high_pad: assert property (
    setup && !pwrite && hit_ah |=> prdata[7] && (prdata[31:8] == 24'h00_0000))
    else $error("high address pad not one");

  a_addr_reset: assert property (
    $rose(presetn) |-> nvm_req.addr == 15'h0000)
    else $error("address not cleared by reset");

  a_cfg_clear: assert property (
    s_cfg_miss |=> s_data_zero ##0 !busy)
    else $error("data not cleared on config miss");

  // idle is checked in the cycle after the load; a new start may follow
  a_word_join: assert property (
    load |=> (nvm_req.word == $past(nvm_read_word)) ##0 !busy)
    else $error("program word not joined from array answer");

endmodule // nvd_regs
`default_nettype wire

/* src/nvd_pkg.sv */
/*
  nvd_pkg: offsets, field positions, reset values and carrier types for the
  nonvolatile data and address holding registers.
  assumes: an 8-bit APB byte address, 32-bit data, one register per word.
*/
package nvd_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_DATA_LOW  = 8'h00;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW  = 8'h08;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CONTROL   = 8'h10;

  // field widths
  localparam int DATA_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 7;
  localparam int ADDR_W      = 15;
  localparam int WORD_W      = 14;

  // fixed bits of the high registers
  localparam logic [1:0] DATA_HIGH_PAD = 2'h0;
  localparam logic       ADDR_HIGH_PAD = 1'b1;

  // reset values, and the values a config miss clears the data pair to
  localparam logic [7:0]             ADDR_LOW_RST  = 8'h00;
  localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RST = 7'h00;
  localparam logic [7:0]             DATA_CLEAR    = 8'h00;
  localparam logic [DATA_HIGH_W-1:0] DATA_H_CLEAR  = 6'h00;
  localparam logic [31:0]            RDATA_RST     = 32'h0000_0000;

  // control register bit positions
  localparam int CTL_READ_START = 0;
  localparam int CTL_CFG_SELECT = 1;
  localparam int CTL_BUSY       = 2;

  // readable configuration space locations
  localparam logic [ADDR_W-1:0] CFG_USER_ID_LAST = 15'h0003;
  localparam logic [ADDR_W-1:0] CFG_DEVICE_ID    = 15'h0006;
  localparam logic [ADDR_W-1:0] CFG_WORD_FIRST   = 15'h0007;
  localparam logic [ADDR_W-1:0] CFG_WORD_LAST    = 15'h0008;

  // access address and program word toward the memory array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] word;
    logic              cfg_space;
  } nvd_req_type;

  typedef enum logic [1:0] {
    NVD_IDLE,
    NVD_READ_WAIT
  } nvd_state_type;

endpackage

/* src/nvd_cfg_window.sv */
/*
  nvd_cfg_window: says whether an address lies in the readable part of the
  configuration space (user ids, device id, configuration words).
  assumes: address is the full 15-bit access address.
*/
`timescale 1ns/1ps
`default_nettype none
module nvd_cfg_window
  import nvd_pkg::*;
(
  // address in
  input  wire logic [ADDR_W-1:0] addr,
  // verdict
  output wire logic              readable
);

  // holes at 4..5 and everything above 8 are not readable
  assign readable = (addr <= CFG_USER_ID_LAST) ||
                    ((addr >= CFG_DEVICE_ID) && (addr <= CFG_WORD_LAST));

endmodule // nvd_cfg_window
`default_nettype wire

/* tb/tb_top.sv */
/*
  tb_top: self-checking bench for the nvm data and address registers.
  assumes: zero-wait apb slave, array answers driven from this bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nvd_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, nvm_read_req, nvm_read_valid;
  logic [WORD_W-1:0] nvm_read_word;
  nvd_req_type       nvm_req;
  logic              err, rq;
  int                miscompares = 0;
  int                n_compared  = 0;

  nvd_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_req(nvm_req),
    .nvm_read_req(nvm_read_req), .nvm_read_valid(nvm_read_valid),
    .nvm_read_word(nvm_read_word));

  // 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data, error and launch pulse taken at pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    rd  = prdata;
    err = pslverr;
    rq  = nvm_read_req;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset held two cycles; used at start and again mid-run
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    nvm_read_valid = 1'b0;
    nvm_read_word = 14'h0000;
    @(posedge pclk);
    do_reset();
    apb(1'b0, OFF_ADDR_LOW, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, OFF_ADDR_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_0080);
    // full-byte writes, upper pwdata bits must not leak in
    apb(1'b1, OFF_DATA_LOW, 32'hFFFF_FFA5);
    apb(1'b1, OFF_DATA_HIGH, 32'h0000_00FF);
    apb(1'b1, OFF_ADDR_LOW, 32'h0000_005A);
    apb(1'b1, OFF_ADDR_HIGH, 32'h0000_007F);
    // software reads back what it has just written
    apb(1'b0, OFF_DATA_LOW, 32'h0000_0000);
    check(rd, 32'h0000_00A5);
    apb(1'b0, OFF_DATA_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_003F);
    apb(1'b0, OFF_ADDR_LOW, 32'h0000_0000);
    check(rd, 32'h0000_005A);
    apb(1'b0, OFF_ADDR_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_00FF);
    check(32'(nvm_req.addr), 32'h0000_7F5A);
    check(32'(nvm_req.word), 32'h0000_3FA5);
    // a zero write must read back zero in the same bits
    apb(1'b1, OFF_DATA_HIGH, 32'h0000_0000);
    apb(1'b0, OFF_DATA_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // unmapped place: error, read zero
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    // array read with a stall before the answer
    apb(1'b1, OFF_CONTROL, 32'h0000_0001);
    check(32'(rq), 32'h0000_0001);
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(32'(rd[2]), 32'h0000_0001);
    nvm_read_valid <= 1'b1;
    nvm_read_word  <= 14'h2ABC;
    @(posedge pclk);
    nvm_read_valid <= 1'b0;
    apb(1'b0, OFF_DATA_LOW, 32'h0000_0000);
    check(rd, 32'h0000_00BC);
    apb(1'b0, OFF_DATA_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_002A);
    // config-space read of a hidden location clears the pair
    apb(1'b1, OFF_ADDR_HIGH, 32'h0000_0000);
    apb(1'b1, OFF_ADDR_LOW, 32'h0000_0010);
    apb(1'b1, OFF_CONTROL, 32'h0000_0003);
    check(32'(rq), 32'h0000_0000);
    apb(1'b0, OFF_DATA_LOW, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, OFF_DATA_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // readable config location launches; a start while busy is dropped
    apb(1'b1, OFF_ADDR_LOW, 32'h0000_0006);
    apb(1'b1, OFF_CONTROL, 32'h0000_0003);
    check(32'(rq), 32'h0000_0001);
    check(32'(nvm_req.cfg_space), 32'h0000_0001);
    apb(1'b1, OFF_CONTROL, 32'h0000_0003);
    check(32'(rq), 32'h0000_0000);
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd, 32'h0000_0006);
    nvm_read_valid <= 1'b1;
    nvm_read_word  <= 14'h1234;
    @(posedge pclk);
    nvm_read_valid <= 1'b0;
    apb(1'b0, OFF_DATA_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_0012);
    check(32'(nvm_req.word), 32'h0000_1234);
    // reset mid-run: address and control clear, data keeps its value
    apb(1'b1, OFF_DATA_LOW, 32'h0000_0033);
    @(posedge pclk);
    do_reset();
    apb(1'b0, OFF_ADDR_LOW, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, OFF_ADDR_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_0080);
    apb(1'b0, OFF_DATA_LOW, 32'h0000_0000);
    check(rd, 32'h0000_0033);
    apb(1'b0, OFF_DATA_HIGH, 32'h0000_0000);
    check(rd, 32'h0000_0012);
    apb(1'b0, OFF_CONTROL, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
